// [hw/btap_top.sv]
// Purpose: Boundary-scan test access port: controller, instruction and data registers.
// Assumes: clk_sys at 25 MHz, several times faster than the tester clock.
// Notes:   Tester pins are oversampled; all scan actions happen on detected edges.
//
// Contract
// - After external test, stay in test operation until a full processor reset.
// - Every undefined instruction code decodes as bypass.
// - TDI has a pull-up so a floating TDI scans in bypass.
// - External test Capture-DR loads input and bidirectional pin values.
// - External test Update-DR drives outputs and bidirectionals from the output latches.
// - Sample/preload Capture-DR loads every input, output and bidirectional pin.
// - Sample/preload Update-DR copies shift stages into the output latches.
// - Sample, bypass and identification leave normal operation alone.
// - Bypass shortens the 281-stage chain to one stage.
// - Identification selects the identification register for shifting out.
// - High impedance floats all outputs and selects the one-stage bypass path.
// - State changes only on rising TCK using TMS sampled there.
// - Reset state on processor reset, TRST#, five TMS highs, or from Select-IR.
// - Entering reset state makes identification active; normal operation untouched.
// - Capture-IR loads 01b low and 000b high into the instruction shifter.
// - Shift-DR moves the selected register toward TDO, MSB from TDI.
// - Shift-IR moves the instruction shifter toward TDO, MSB from TDI.
// - Update-IR loads the instruction latch, which alone sets the instruction.
// - Pause holds shifting; Exit2 returns or updates; no other effect.
// - Run-Test/Idle does no capture, shift or update.
// - Codes 00000b external test, 00001b sample, 00010b identification.
// - 00011b high impedance; 00100b to 11110b bypass; 11111b explicit bypass.
// - Identification is 32 bits: version 4, part 16, maker 11, LSB one.
// - Bypass path is one shift stage between TDI and TDO.
`include "btap_consts.svh"
`default_nettype none

module btap_top #(
  parameter int                         CHAIN_LEN = `BTAP_CHAIN_LEN,
  parameter logic [3:0]                 ID_VERSION = `BTAP_ID_VERSION,  // Arbitrary value.
  parameter logic [15:0]                ID_PART    = `BTAP_ID_PART,     // Arbitrary value.
  parameter logic [10:0]                ID_MAKER   = `BTAP_ID_MAKER,    // Arbitrary value.
  parameter logic [CHAIN_LEN-1:0]       OUT_ONLY   = '0,
  parameter logic [CHAIN_LEN-1:0]       DRIVABLE   = '1
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire btap_pkg::btap_jin_t      jtag_in,
  input  wire logic                     trst_n,
  input  wire logic                     cpu_reset,
  input  wire logic [CHAIN_LEN-1:0]     pad_in,
  input  wire logic [CHAIN_LEN-1:0]     core_out,
  input  wire logic [CHAIN_LEN-1:0]     core_oe,
  output var  btap_pkg::btap_jout_t     jtag_out,
  output var  logic [CHAIN_LEN-1:0]     pad_out_r,
  output var  logic [CHAIN_LEN-1:0]     pad_oe_r,
  output var  logic                     test_mode_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for every pin that comes from outside clk_sys.

  logic [2:0]            tck_sy_r;
  logic [1:0]            tms_sy_r;
  logic [1:0]            tdi_sy_r;
  logic [1:0]            rst_sy_r;
  logic [CHAIN_LEN-1:0]  pad_s1_r;
  logic [CHAIN_LEN-1:0]  pad_s2_r;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      // Starts at the tester's idle high level, so a parked clock never reads as a rise.
      tck_sy_r <= 3'h7;
      tms_sy_r <= 2'h3;
      tdi_sy_r <= 2'h3;
      rst_sy_r <= 2'h0;
      pad_s1_r <= '0;
      pad_s2_r <= '0;
    end else begin
      tck_sy_r <= {tck_sy_r[1:0], jtag_in.tck};
      tms_sy_r <= {tms_sy_r[0], jtag_in.tms};
      tdi_sy_r <= {tdi_sy_r[0], jtag_in.tdi};
      rst_sy_r <= {rst_sy_r[0], cpu_reset};
      pad_s1_r <= pad_in;
      pad_s2_r <= pad_s1_r;
    end
  end

  // Edge detection reads only the second and third stages.
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;
  logic cpu_rst_s;
  logic tap_rst;

  assign tck_rise  = tck_sy_r[1] & ~tck_sy_r[2];
  assign tck_fall  = ~tck_sy_r[1] & tck_sy_r[2];
  assign tms_s     = tms_sy_r[1];
  // With the pad pull-up an open TDI reads one, so an instruction scan loads all ones.
  assign tdi_s     = tdi_sy_r[1];
  assign cpu_rst_s = rst_sy_r[1];
  // The tester reset acts at once without any clock, but its release is retimed.
  // A raw release could land near a clk_sys edge and leave the port half reset.
  logic       tap_arst;
  logic [1:0] trst_sy_r;

  assign tap_arst = reset | ~trst_n;

  always_ff @(posedge clk_sys or posedge tap_arst) begin
    if (tap_arst) begin
      trst_sy_r <= 2'h3;
    end else begin
      trst_sy_r <= {trst_sy_r[0], 1'h0};
    end
  end

  assign tap_rst   = trst_sy_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Controller.

  btap_pkg::btap_state_t st;

  btap_fsm u_fsm (
    .clk_sys   (clk_sys),
    .rst       (tap_rst),
    .force_tlr (cpu_rst_s),
    .tck_rise  (tck_rise),
    .tms       (tms_s),
    .state_r   (st)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode from the latched code alone.

  logic [`BTAP_IR_W-1:0]  ir_sh_r;
  logic [`BTAP_IR_W-1:0]  ir_sh_nxt;
  logic [`BTAP_IR_W-1:0]  ir_r;
  logic [`BTAP_IR_W-1:0]  ir_nxt;
  btap_pkg::btap_instr_t  instr;

  always_comb begin
    case (ir_r)
      `BTAP_CODE_EXTEST: instr = btap_pkg::IN_EXTEST;
      `BTAP_CODE_SAMPLE: instr = btap_pkg::IN_SAMPLE;
      `BTAP_CODE_IDCODE: instr = btap_pkg::IN_IDCODE;
      `BTAP_CODE_HIGHZ:  instr = btap_pkg::IN_HIGHZ;
      `BTAP_CODE_BYPASS: instr = btap_pkg::IN_BYPASS;
      default:           instr = btap_pkg::IN_BYPASS;
    endcase
  end

  logic sel_chain;
  logic sel_id;
  logic sel_byp;

  assign sel_chain = (instr == btap_pkg::IN_EXTEST) | (instr == btap_pkg::IN_SAMPLE);
  assign sel_id    = (instr == btap_pkg::IN_IDCODE);
  assign sel_byp   = ~sel_chain & ~sel_id;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction registers.

  always_comb begin
    ir_sh_nxt = ir_sh_r;
    ir_nxt    = ir_r;
    if (st == btap_pkg::ST_TLR) begin
      ir_nxt = `BTAP_CODE_IDCODE;
    end else if (tck_rise) begin
      case (st)
        btap_pkg::ST_CAPIR: ir_sh_nxt = `BTAP_IR_CAPTURE;
        btap_pkg::ST_SHIR:  ir_sh_nxt = {tdi_s, ir_sh_r[`BTAP_IR_W-1:1]};
        btap_pkg::ST_UPIR:  ir_nxt    = ir_sh_r;
        default:            ir_sh_nxt = ir_sh_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge tap_rst) begin
    if (tap_rst) begin
      ir_sh_r <= `BTAP_IR_CAPTURE;
      ir_r    <= `BTAP_CODE_IDCODE;
    end else begin
      ir_sh_r <= ir_sh_nxt;
      ir_r    <= ir_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data registers: boundary chain shifter and latches, identification, bypass.

  logic [CHAIN_LEN-1:0]   chain_sh_r;
  logic [CHAIN_LEN-1:0]   chain_sh_nxt;
  logic [CHAIN_LEN-1:0]   chain_upd_r;
  logic [CHAIN_LEN-1:0]   chain_upd_nxt;
  logic [`BTAP_ID_W-1:0]  id_sh_r;
  logic [`BTAP_ID_W-1:0]  id_sh_nxt;
  logic                   byp_r;
  logic                   byp_nxt;
  logic [`BTAP_ID_W-1:0]  id_value;

  assign id_value = {ID_VERSION, ID_PART, ID_MAKER, `BTAP_ID_LSB};

  always_comb begin
    chain_sh_nxt  = chain_sh_r;
    chain_upd_nxt = chain_upd_r;
    id_sh_nxt     = id_sh_r;
    byp_nxt       = byp_r;
    if (tck_rise) begin
      case (st)
        btap_pkg::ST_CAPDR: begin
          if (instr == btap_pkg::IN_EXTEST) begin
            // Output-only cells have no pin to sample here, so they keep their stage.
            chain_sh_nxt = (pad_s2_r & ~OUT_ONLY) | (chain_sh_r & OUT_ONLY);
          end else if (instr == btap_pkg::IN_SAMPLE) begin
            chain_sh_nxt = (pad_s2_r & ~OUT_ONLY) | (pad_out_r & OUT_ONLY);
          end
          id_sh_nxt = id_value;
          byp_nxt   = 1'h0;
        end
        btap_pkg::ST_SHDR: begin
          if (sel_chain) begin
            chain_sh_nxt = {tdi_s, chain_sh_r[CHAIN_LEN-1:1]};
          end
          if (sel_id) begin
            id_sh_nxt = {tdi_s, id_sh_r[`BTAP_ID_W-1:1]};
          end
          if (sel_byp) begin
            byp_nxt = tdi_s;
          end
        end
        btap_pkg::ST_UPDR: begin
          // Both chain instructions update the latches; only external test drives pins.
          if (sel_chain) begin
            chain_upd_nxt = chain_sh_r;
          end
        end
        default: begin
          chain_sh_nxt = chain_sh_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge tap_rst) begin
    if (tap_rst) begin
      chain_sh_r  <= '0;
      chain_upd_r <= '0;
      id_sh_r     <= '0;
      byp_r       <= 1'h0;
    end else begin
      chain_sh_r  <= chain_sh_nxt;
      chain_upd_r <= chain_upd_nxt;
      id_sh_r     <= id_sh_nxt;
      byp_r       <= byp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test hold: once external test is active only a processor reset or the block reset ends it.
  // The tester reset does not clear it, so the pins never glitch back mid-test.

  logic ext_hold_r;
  logic ext_hold_nxt;

  always_comb begin
    ext_hold_nxt = ext_hold_r;
    if (instr == btap_pkg::IN_EXTEST) begin
      ext_hold_nxt = 1'h1;
    end else if (cpu_rst_s) begin
      ext_hold_nxt = 1'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ext_hold_r <= 1'h0;
    end else begin
      ext_hold_r <= ext_hold_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and serial output.

  logic [CHAIN_LEN-1:0]   pad_out_nxt;
  logic [CHAIN_LEN-1:0]   pad_oe_nxt;
  btap_pkg::btap_jout_t   jtag_out_nxt;
  logic                   test_mode_nxt;
  logic                   tdo_src;

  always_comb begin
    case (st)
      btap_pkg::ST_SHIR: tdo_src = ir_sh_r[0];
      btap_pkg::ST_SHDR: tdo_src = sel_chain ? chain_sh_r[0] : (sel_id ? id_sh_r[0] : byp_r);
      default:           tdo_src = 1'h0;
    endcase
  end

  always_comb begin
    jtag_out_nxt  = jtag_out;
    test_mode_nxt = ext_hold_r;
    if (tck_fall) begin
      jtag_out_nxt.tdo_oe = (st == btap_pkg::ST_SHIR) | (st == btap_pkg::ST_SHDR);
      jtag_out_nxt.tdo    = tdo_src;
    end
    if (instr == btap_pkg::IN_HIGHZ) begin
      pad_out_nxt = core_out;
      pad_oe_nxt  = '0;
    end else if (ext_hold_r) begin
      pad_out_nxt = chain_upd_r;
      pad_oe_nxt  = DRIVABLE;
    end else begin
      pad_out_nxt = core_out;
      pad_oe_nxt  = core_oe;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      jtag_out    <= '0;
      pad_out_r   <= '0;
      pad_oe_r    <= '0;
      test_mode_r <= 1'h0;
    end else begin
      jtag_out    <= jtag_out_nxt;
      pad_out_r   <= pad_out_nxt;
      pad_oe_r    <= pad_oe_nxt;
      test_mode_r <= test_mode_nxt;
    end
  end

endmodule : btap_top

`default_nettype wire

// [inc/btap_consts.svh]
// Purpose: Named constants for the boundary-scan test access port.
// Assumes: Included by the package and the design files by bare name.
// Notes:   Definitions only.
`ifndef BTAP_CONSTS_SVH
`define BTAP_CONSTS_SVH

`define BTAP_IR_W          5
`define BTAP_ID_W          32
`define BTAP_CHAIN_LEN     281
`define BTAP_CODE_EXTEST   5'h00
`define BTAP_CODE_SAMPLE   5'h01
`define BTAP_CODE_IDCODE   5'h02
`define BTAP_CODE_HIGHZ    5'h03
`define BTAP_CODE_BYPASS   5'h1F
`define BTAP_IR_CAPTURE    5'h01
`define BTAP_TMS_ONES_MAX  3'h5
`define BTAP_ID_VERSION    4'h0
`define BTAP_ID_PART       16'h1234
`define BTAP_ID_MAKER      11'h2A5
`define BTAP_ID_LSB        1'h1

`endif

// [inc/btap_pkg.sv]
// Purpose: Types shared by the boundary-scan test access port files.
// Assumes: Nothing beyond the constants header.
// Notes:   States are one-hot with the codes written out.
`include "btap_consts.svh"
`default_nettype none

package btap_pkg;

  typedef enum logic [15:0] {
    ST_TLR   = 16'h0001,
    ST_RTI   = 16'h0002,
    ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008,
    ST_SHDR  = 16'h0010,
    ST_EX1DR = 16'h0020,
    ST_PSDR  = 16'h0040,
    ST_EX2DR = 16'h0080,
    ST_UPDR  = 16'h0100,
    ST_SELIR = 16'h0200,
    ST_CAPIR = 16'h0400,
    ST_SHIR  = 16'h0800,
    ST_EX1IR = 16'h1000,
    ST_PSIR  = 16'h2000,
    ST_EX2IR = 16'h4000,
    ST_UPIR  = 16'h8000
  } btap_state_t;

  typedef enum logic [4:0] {
    IN_EXTEST = 5'h01,
    IN_SAMPLE = 5'h02,
    IN_IDCODE = 5'h04,
    IN_HIGHZ  = 5'h08,
    IN_BYPASS = 5'h10
  } btap_instr_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } btap_jin_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } btap_jout_t;

endpackage : btap_pkg

`default_nettype wire

// [hw/btap_fsm.sv]
// Purpose: Sixteen-state scan controller stepped by sampled rising link-clock edges.
// Assumes: tck_rise and tms come from the same clk_sys domain, already synchronised.
// Notes:   rst is asynchronous and gathers the block reset and the tester reset.
`include "btap_consts.svh"
`default_nettype none

module btap_fsm (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               force_tlr,
  input  wire logic               tck_rise,
  input  wire logic               tms,
  output var  btap_pkg::btap_state_t state_r
);

  btap_pkg::btap_state_t state_nxt;
  logic [2:0]            ones_r;
  logic [2:0]            ones_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    ones_nxt  = ones_r;
    if (tck_rise) begin
      // Saturating count of consecutive high TMS samples.
      ones_nxt = tms ? ((ones_r == `BTAP_TMS_ONES_MAX) ? ones_r : ones_r + 3'h1) : 3'h0;
      case (state_r)
        btap_pkg::ST_TLR:   state_nxt = tms ? btap_pkg::ST_TLR   : btap_pkg::ST_RTI;
        btap_pkg::ST_RTI:   state_nxt = tms ? btap_pkg::ST_SELDR : btap_pkg::ST_RTI;
        btap_pkg::ST_SELDR: state_nxt = tms ? btap_pkg::ST_SELIR : btap_pkg::ST_CAPDR;
        btap_pkg::ST_CAPDR: state_nxt = tms ? btap_pkg::ST_EX1DR : btap_pkg::ST_SHDR;
        btap_pkg::ST_SHDR:  state_nxt = tms ? btap_pkg::ST_EX1DR : btap_pkg::ST_SHDR;
        btap_pkg::ST_EX1DR: state_nxt = tms ? btap_pkg::ST_UPDR  : btap_pkg::ST_PSDR;
        btap_pkg::ST_PSDR:  state_nxt = tms ? btap_pkg::ST_EX2DR : btap_pkg::ST_PSDR;
        btap_pkg::ST_EX2DR: state_nxt = tms ? btap_pkg::ST_UPDR  : btap_pkg::ST_SHDR;
        btap_pkg::ST_UPDR:  state_nxt = tms ? btap_pkg::ST_SELDR : btap_pkg::ST_RTI;
        btap_pkg::ST_SELIR: state_nxt = tms ? btap_pkg::ST_TLR   : btap_pkg::ST_CAPIR;
        btap_pkg::ST_CAPIR: state_nxt = tms ? btap_pkg::ST_EX1IR : btap_pkg::ST_SHIR;
        btap_pkg::ST_SHIR:  state_nxt = tms ? btap_pkg::ST_EX1IR : btap_pkg::ST_SHIR;
        btap_pkg::ST_EX1IR: state_nxt = tms ? btap_pkg::ST_UPIR  : btap_pkg::ST_PSIR;
        btap_pkg::ST_PSIR:  state_nxt = tms ? btap_pkg::ST_EX2IR : btap_pkg::ST_PSIR;
        btap_pkg::ST_EX2IR: state_nxt = tms ? btap_pkg::ST_UPIR  : btap_pkg::ST_SHIR;
        btap_pkg::ST_UPIR:  state_nxt = tms ? btap_pkg::ST_SELDR : btap_pkg::ST_RTI;
        default:            state_nxt = btap_pkg::ST_TLR;
      endcase
      // The table already reaches reset after five highs; this guards a corrupted state.
      if (ones_nxt == `BTAP_TMS_ONES_MAX) begin
        state_nxt = btap_pkg::ST_TLR;
      end
    end
    if (force_tlr) begin
      state_nxt = btap_pkg::ST_TLR;
      ones_nxt  = 3'h0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= btap_pkg::ST_TLR;
      ones_r  <= 3'h0;
    end else begin
      state_r <= state_nxt;
      ones_r  <= ones_nxt;
    end
  end

endmodule : btap_fsm

`default_nettype wire

// [testbench/btap_top_properties.sv]
// Purpose: Port-level properties of the boundary-scan test access port.
// Assumes: Tester clock phases last at least four system clocks.
// Notes:   Bound into btap_top; sees its ports only.
`default_nettype none

module btap_top_properties #(
  parameter int                   CHAIN_LEN = 281,
  parameter logic [CHAIN_LEN-1:0] DRIVABLE  = '1
) (
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire btap_pkg::btap_jin_t    jtag_in,
  input wire logic                   trst_n,
  input wire logic                   cpu_reset,
  input wire logic [CHAIN_LEN-1:0]   core_out,
  input wire logic [CHAIN_LEN-1:0]   core_oe,
  input wire btap_pkg::btap_jout_t   jtag_out,
  input wire logic [CHAIN_LEN-1:0]   pad_out_r,
  input wire logic [CHAIN_LEN-1:0]   pad_oe_r,
  input wire logic                   test_mode_r
);
  timeunit 1ns;
  timeprecision 1ns;
  // The tester reset may clear scan state at any moment, so it mutes the checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset || !trst_n);

  AST_TDO_FALL: assert property (
    $changed(jtag_out.tdo) |-> !$past(jtag_in.tck, 3) || !$past(jtag_in.tck, 4))
    else $error("serial out moved away from a falling scan clock");
  AST_TDO_OE_FALL: assert property (
    $changed(jtag_out.tdo_oe) |-> !$past(jtag_in.tck, 3) || !$past(jtag_in.tck, 4))
    else $error("serial out enable moved away from a falling scan clock");
  AST_TDO_OE_SPAN: assert property (
    $rose(jtag_out.tdo_oe) |-> jtag_out.tdo_oe [*8])
    else $error("serial out enable shorter than one scan clock");
  AST_OE_SOURCES: assert property (
    pad_oe_r == '0 || pad_oe_r == $past(core_oe) || pad_oe_r == DRIVABLE)
    else $error("pin enables from an unknown source");
  AST_HOLD_CLEAR: assert property (
    $fell(test_mode_r) |-> $past(cpu_reset, 2))
    else $error("test hold left without processor reset");
  AST_HOLD_OE: assert property (
    test_mode_r && $past(test_mode_r) |-> pad_oe_r == DRIVABLE || pad_oe_r == '0)
    else $error("held test enables wrong");
  AST_NORMAL_PINS: assert property (
    !test_mode_r && !$past(test_mode_r) && pad_oe_r != '0
      |-> pad_out_r == $past(core_out) && pad_oe_r == $past(core_oe))
    else $error("normal pins disturbed");
  AST_UPDATE_RISE: assert property (
    test_mode_r && $past(test_mode_r) && $changed(pad_out_r)
      |-> $past(jtag_in.tck, 3) || $past(jtag_in.tck, 4))
    else $error("held pins changed away from a rising scan clock");
endmodule : btap_top_properties

bind btap_top btap_top_properties #(.CHAIN_LEN(CHAIN_LEN), .DRIVABLE(DRIVABLE)) i_props (
  .clk_sys    (clk_sys),
  .reset      (reset),
  .jtag_in    (jtag_in),
  .trst_n     (trst_n),
  .cpu_reset  (cpu_reset),
  .core_out   (core_out),
  .core_oe    (core_oe),
  .jtag_out   (jtag_out),
  .pad_out_r  (pad_out_r),
  .pad_oe_r   (pad_oe_r),
  .test_mode_r(test_mode_r)
);

`default_nettype wire

// [testbench/btap_tester.sv]
// Purpose: Boundary-scan tester model driving scan clock, mode, data and tester reset.
// Assumes: A step is 4 system clocks low and 4 high, changed on falling clk_sys.
// Notes:   The scan clock stands high between steps; data in rests high like its pull-up.
`default_nettype none

module btap_tester (
  input  wire logic                 clk_sys,
  input  wire btap_pkg::btap_jout_t jtag_out,
  output var  btap_pkg::btap_jin_t  jtag_in,
  output var  logic                 trst_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    jtag_in = '{tck: 1'h1, tms: 1'h0, tdi: 1'h1};
    trst_n = 1'h1;
  end

  // Serial out is read late in the high phase, since it stands until the next fall.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    @(negedge clk_sys);
    jtag_in = '{tck: 1'h0, tms: tms, tdi: tdi};
    repeat (4) @(negedge clk_sys);
    jtag_in.tck = 1'h1;
    repeat (3) @(negedge clk_sys);
    tdo = jtag_out.tdo;
  endtask : step
endmodule : btap_tester

`default_nettype wire

// [testbench/btap_top_test.sv]
// Purpose: Self-checking bench of the boundary-scan test access port.
// Assumes: Full 281-stage chain; identification fields set here.
// Notes:   Scans run through the tester model; pins are checked after each t_codes instruction update and each t_extest data scan.
`default_nettype none

module btap_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 281;
  localparam logic [31:0] ID = {4'hA, 16'h5A3C, 11'h155, 1'h1}; // Arbitrary fields.

  logic                 clk_sys = 1'h0;
  logic                 reset = 1'h1;
  logic                 cpu_reset = 1'h0;
  logic                 trst_n, test_mode_r, d;
  logic [N-1:0]         pad_in, core_out, core_oe, pad_out_r, pad_oe_r, pa, pb, o;
  btap_pkg::btap_jin_t  jtag_in;
  btap_pkg::btap_jout_t jtag_out;
  int                   failures = 0;
  int                   comparisons = 0;

  always #20 clk_sys = ~clk_sys;

  btap_top #(.ID_VERSION(4'hA), .ID_PART(16'h5A3C), .ID_MAKER(11'h155)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .jtag_in(jtag_in), .trst_n(trst_n),
    .cpu_reset(cpu_reset), .pad_in(pad_in), .core_out(core_out), .core_oe(core_oe),
    .jtag_out(jtag_out), .pad_out_r(pad_out_r), .pad_oe_r(pad_oe_r),
    .test_mode_r(test_mode_r)
  );
  btap_tester i_tst (.clk_sys(clk_sys), .jtag_out(jtag_out), .jtag_in(jtag_in), .trst_n(trst_n));

  //////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [N-1:0] seen, input logic [N-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // From reset or idle: one scan, optionally paused after bit pause_at, ending in idle.
  task automatic scan(input logic ir, input int n, input logic [N-1:0] din,
                      output logic [N-1:0] dout, input int pause_at);
    int oe_n;
    oe_n = 0;
    dout = '0;
    i_tst.step(1'h0, 1'h1, d);
    i_tst.step(1'h1, 1'h1, d);
    if (ir)
      i_tst.step(1'h1, 1'h1, d);
    repeat (2) i_tst.step(1'h0, 1'h1, d);
    for (int i = 0; i < n; i++) begin
      i_tst.step(i == n - 1 || i == pause_at, din[i], dout[i]);
      oe_n += jtag_out.tdo_oe;
      if (i == pause_at && i < n - 1) begin
        repeat (2) i_tst.step(1'h0, 1'h1, d);
        i_tst.step(1'h1, 1'h1, d);
        i_tst.step(1'h0, 1'h1, d);
      end
    end
    i_tst.step(1'h1, 1'h1, d);
    i_tst.step(1'h0, 1'h1, d);
    // Pins follow an update only after synchronising and one register stage.
    repeat (6) @(negedge clk_sys);
    check("tdo enable count", N'(oe_n), N'(n));
    check("tdo enable idle", N'(jtag_out.tdo_oe), N'(1'h0));
  endtask : scan

  task automatic ir(input logic [4:0] code);
    scan(1'h1, 5, N'(code), o, -1);
    check("ir capture", o, N'(5'h01));
  endtask : ir

  //////////////////////////////////////////////////////////////////////
  task automatic t_idcode;
    scan(1'h0, 32, '1, o, 15);
    check("idcode", o, N'(ID));
  endtask : t_idcode

  task automatic t_codes;
    for (int c = 3; c < 32; c++) begin
      ir(c[4:0]);
      check("pin enables", pad_oe_r, c == 3 ? '0 : core_oe);
      check("pin values", pad_out_r, core_out);
      scan(1'h0, 2, N'(2'h3), o, -1);
      check("bypass", o, N'(2'h2));
    end
  endtask : t_codes

  task automatic t_trst;
    ir(5'h01);
    @(negedge clk_sys);
    i_tst.trst_n = 1'h0;
    repeat (3) @(negedge clk_sys);
    i_tst.trst_n = 1'h1;
    t_idcode();
  endtask : t_trst

  task automatic t_extest;
    ir(5'h01);
    scan(1'h0, N, pb, o, -1);
    check("sample capture", o, pa);
    check("sample pins", pad_out_r, core_out);
    ir(5'h00);
    check("hold flag", N'(test_mode_r), N'(1'h1));
    check("preloaded pins", pad_out_r, pb);
    check("held enables", pad_oe_r, '1);
    pad_in = pb;
    scan(1'h0, N, pa, o, 140);
    check("extest capture", o, pb);
    check("updated pins", pad_out_r, pa);
    ir(5'h1F);
    repeat (5) i_tst.step(1'h1, 1'h1, d);
    check("still held", N'(test_mode_r), N'(1'h1));
    cpu_reset = 1'h1;
    repeat (6) @(negedge clk_sys);
    cpu_reset = 1'h0;
    repeat (4) @(negedge clk_sys);
    check("released", N'(test_mode_r), N'(1'h0));
    check("normal pins", pad_out_r, core_out);
  endtask : t_extest

  initial begin
    for (int i = 0; i < N; i++) begin
      pa[i] = (i % 3 == 0);
      pb[i] = (i % 5 != 1);
    end
    pad_in = pa;
    core_out = pb;
    core_oe = ~pa;
    repeat (8) @(negedge clk_sys);
    reset = 1'h0;
    repeat (3) @(negedge clk_sys);
    t_idcode();
    t_codes();
    t_trst();
    t_extest();
    t_idcode();
    complete_run();
  end

  // About four times the expected run length.
  initial begin
    #2000000;
    failures++;
    complete_run();
  end
endmodule : btap_top_test

`default_nettype wire
